// ===== include/asr_pkg.sv
// Constants shared by the angle sensor register block and its SPI link.
// Assumes a single clk domain core and an SPI clock from the host.
package asr_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ANGLE_W = 16;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 5;
  localparam int OP_W    = 3;
  localparam int FRAME_W = 16;
  localparam int FIELD_W = 8;
  localparam int CODE_W  = 3;
  localparam int CNT_W   = 5;

  // ****************************************
  // Frame layout and opcodes
  // ****************************************
  localparam int OP_LSB   = 13;
  localparam int ADDR_LSB = 8;
  localparam logic [OP_W-1:0] OP_READ  = 3'h2;
  localparam logic [OP_W-1:0] OP_WRITE = 3'h4;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_ZERO_LO   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_HI   = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_AMT  = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_EN   = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_FIELD_CFG = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_DIR       = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_FIELD_ST  = 5'h1b;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int TRIMX_BIT  = 0;
  localparam int TRIMY_BIT  = 1;
  localparam int DETECT_BIT = 0;
  localparam int HIGHT_LSB  = 1;
  localparam int LOWT_LSB   = 4;
  localparam int DIR_BIT    = 7;
  localparam int HIGHF_BIT  = 7;
  localparam int LOWF_BIT   = 6;
  localparam logic [DATA_W-1:0]  BYTE_RST      = 8'h00;
  localparam logic [DATA_W-1:0]  FIELD_CFG_RST = 8'h1d;
  localparam logic [ANGLE_W-1:0] ANGLE_RST     = 16'h0000;

  // ****************************************
  // Field levels in mT (rising edge) and hysteresis
  // ****************************************
  localparam logic [FIELD_W-1:0] RISE_MT [8] = '{
    8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
  localparam logic [FIELD_W-1:0] HYST_MT   = 8'h06;
  localparam logic [8:0]         TRIM_FULL = 9'h100;

endpackage

// ===== include/asr_link_if.sv
// Carrier between the SPI link logic (sclk) and the register core (clk).
// Assumes the frame word and reply word stay still while read across.
`timescale 1ns/1ps
interface asr_link_if;
  import asr_pkg::*;
  logic [FRAME_W-1:0] frame_word;
  logic               frame_tgl;
  logic [FRAME_W-1:0] reply_word;
  modport link (
    output frame_word,
    output frame_tgl,
    input  reply_word
  );
  modport core (
    input  frame_word,
    input  frame_tgl,
    output reply_word
  );
endinterface

// ===== src/asr_field_alarm.sv
// One field alarm comparator with hysteresis, low or high side.
// Assumes field and code come from the clk domain.
`timescale 1ns/1ps
module asr_field_alarm #(
  parameter bit HIGH_SIDE = 1'b0
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         enable,
  input  wire logic [asr_pkg::CODE_W-1:0]   code,
  input  wire logic [asr_pkg::FIELD_W-1:0]  field,
  output logic                              flag
);
  import asr_pkg::*;

  logic [FIELD_W-1:0] rise_lvl;
  logic [FIELD_W-1:0] fall_lvl;
  logic               above;
  logic               below;

  // Switching levels sit HYST_MT apart
  assign rise_lvl = RISE_MT[code];
  assign fall_lvl = rise_lvl - HYST_MT;
  assign above    = field >= rise_lvl;
  assign below    = field < fall_lvl;

  // Each side holds its state between the two levels
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      flag <= 1'b0;
    end else if (HIGH_SIDE) begin
      if (above) flag <= 1'b1;
      else if (below) flag <= 1'b0;
    end else begin
      if (below) flag <= 1'b1;
      else if (above) flag <= 1'b0;
    end
  end
endmodule

// ===== src/asr_spi_link.sv
// SPI slave shifter on the host's clock, mode 0, MSB first, 16 bits.
// Assumes sclk runs only while cs_n is low.
`timescale 1ns/1ps
module asr_spi_link (
  input  wire logic   sclk,
  input  wire logic   srst,
  input  wire logic   cs_n,
  input  wire logic   mosi,
  output logic        miso,
  output logic        miso_oe,
  asr_link_if.link    lk
);
  import asr_pkg::*;

  logic [CNT_W-1:0]   cnt_r;
  logic [FRAME_W-1:0] shift_r;
  logic               miso_r;
  logic [3:0]         bit_idx;
  logic               last_bit;

  assign bit_idx  = 4'hf - cnt_r[3:0];
  assign last_bit = cnt_r == CNT_W'(FRAME_W - 1);

  // Bit counter restarts whenever the host deselects
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_r   <= '0;
      shift_r <= '0;
    end else begin
      if (!cnt_r[CNT_W-1]) cnt_r <= cnt_r + 1'b1;
      shift_r <= {shift_r[FRAME_W-2:0], mosi};
    end
  end

  // Whole frame handed to the core by a toggle; word stays until next end
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      lk.frame_word <= '0;
      lk.frame_tgl  <= 1'b0;
    end else if (!cs_n && last_bit) begin
      lk.frame_word <= {shift_r[FRAME_W-2:0], mosi};
      lk.frame_tgl  <= ~lk.frame_tgl;
    end
  end

  // Next reply bit on the falling edge; MSB shows from select onward
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) miso_r <= 1'b0;
    else miso_r <= cnt_r[CNT_W-1] ? 1'b0 : lk.reply_word[bit_idx];
  end

  assign miso    = (cnt_r == '0) ? lk.reply_word[FRAME_W-1] : miso_r;
  assign miso_oe = !cs_n;
endmodule

// ===== src/asr_angle_cfg.sv
// Register core of the magnetic angle sensor: zero offset, direction,
// bias trim, field alarms and the SPI register access path.
// Assumes raw_angle and field_mt come from front-end logic on clk;
// the SPI pins come from the host and run on sclk.
//
// Notes on behaviour
// - Output angle equals raw angle, negated when direction bit is set, minus 16-bit zero offset.
// - Direction bit clear: clockwise positive; set: counterclockwise positive.
// - Bias trim amount is an unsigned 8-bit value applied to an axis.
// - Separate X and Y enables pick which axis bias is reduced.
// - Both enables set reduce both axes equally.
// - Low and high flags assert when field leaves the threshold range.
// - Both flags switch with 6 mT hysteresis.
// - Thresholds are 3-bit fields: low at bits 6:4, high at 3:1.
// - Code 000 switches at 26/20 mT, 111 at 126/120 mT.
// - Low code may exceed high code; each flag judged alone.
// - Both trims on: larger trim amount raises effective thresholds.
// - Status register holds high flag bit 7, low flag bit 6; pins too.
// - Addressed register returns in the next frame, high angle byte on top.
// - Detect enable bit gates the field alarm comparison.
`timescale 1ns/1ps
module asr_angle_cfg (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          mosi,
  output logic                               miso,
  output logic                               miso_oe,
  input  wire logic [asr_pkg::ANGLE_W-1:0]   raw_angle,
  input  wire logic [asr_pkg::FIELD_W-1:0]   field_mt,
  output logic      [asr_pkg::ANGLE_W-1:0]   angle_out,
  output logic      [asr_pkg::DATA_W-1:0]    trim_x,
  output logic      [asr_pkg::DATA_W-1:0]    trim_y,
  output logic                               low_field_flag,
  output logic                               high_field_flag
);
  import asr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************

  // Link carrier between the two domains
  asr_link_if lk ();

  // Software-visible settings
  logic [ANGLE_W-1:0] zero_r;
  logic [DATA_W-1:0]  bias_trim_amount_r;
  logic               trim_enable_x_r;
  logic               trim_enable_y_r;
  logic [DATA_W-1:0]  field_cfg_r;
  logic               dir_r;

  // Crossing flip-flops
  logic               cs_s1_r;
  logic               cs_s2_r;
  logic               tgl_s1_r;
  logic               tgl_s2_r;
  logic               tgl_seen_r;

  // Reply path state
  logic               pend_r;
  logic [ADDR_W-1:0]  reply_addr_r;
  logic [FRAME_W-1:0] reply_r;
  logic [FRAME_W-1:0] reply_nxt;

  // Angle path
  logic [ANGLE_W-1:0] angle_nxt;
  logic [ANGLE_W-1:0] angle_r;

  // Field path
  logic [16:0]        scaled_prod;
  logic [FIELD_W-1:0] field_eff;
  logic               both_trim;
  logic [1:0]         flag_w;
  logic [CODE_W-1:0]  code_w [2];

  // Decoded frame
  logic               frame_evt;
  logic [OP_W-1:0]    op_w;
  logic [ADDR_W-1:0]  addr_w;
  logic [DATA_W-1:0]  wdata_w;
  logic               wr_evt;
  logic               rd_evt;
  logic               wr_zero_lo;
  logic               wr_zero_hi;
  logic               wr_trim_amt;
  logic               wr_trim_en;
  logic               wr_field_cfg;
  logic               wr_dir;
  logic [DATA_W-1:0]  rd_data;
  logic [DATA_W-1:0]  status_w;
  logic               detect_en;

  // ****************************************
  // SPI link on the host clock
  // ****************************************

  // Shifter, frame capture and reply serialiser live on sclk
  asr_spi_link u_link (
    .sclk    (sclk),
    .srst    (srst),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .lk      (lk.link)
  );

  // ****************************************
  // Crossing into clk
  // ****************************************

  // Two flip-flops for the select level and the frame toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
    end else begin
      cs_s1_r  <= cs_n;
      cs_s2_r  <= cs_s1_r;
      tgl_s1_r <= lk.frame_tgl;
      tgl_s2_r <= tgl_s1_r;
    end
  end

  // Last toggle value handled; a change marks one new frame
  always_ff @(posedge clk) begin
    if (srst) tgl_seen_r <= 1'b0;
    else tgl_seen_r <= tgl_s2_r;
  end

  assign frame_evt = tgl_s2_r ^ tgl_seen_r;

  // ****************************************
  // Frame decode
  // ****************************************

  // Frame word is still when the toggle arrives, so it is safe to read
  assign op_w    = lk.frame_word[OP_LSB +: OP_W];
  assign addr_w  = lk.frame_word[ADDR_LSB +: ADDR_W];
  assign wdata_w = lk.frame_word[DATA_W-1:0];
  assign wr_evt  = frame_evt && (op_w == OP_WRITE);
  assign rd_evt  = frame_evt && (op_w == OP_READ);

  // Write strobes; the status address takes no write
  assign wr_zero_lo   = wr_evt && (addr_w == ADDR_ZERO_LO);
  assign wr_zero_hi   = wr_evt && (addr_w == ADDR_ZERO_HI);
  assign wr_trim_amt  = wr_evt && (addr_w == ADDR_TRIM_AMT);
  assign wr_trim_en   = wr_evt && (addr_w == ADDR_TRIM_EN);
  assign wr_field_cfg = wr_evt && (addr_w == ADDR_FIELD_CFG);
  assign wr_dir       = wr_evt && (addr_w == ADDR_DIR);

  // ****************************************
  // Setting registers
  // ****************************************

  // Zero offset, low then high byte
  always_ff @(posedge clk) begin
    if (srst) begin
      zero_r <= ANGLE_RST;
    end else begin
      if (wr_zero_lo) zero_r[DATA_W-1:0] <= wdata_w;
      if (wr_zero_hi) zero_r[ANGLE_W-1:DATA_W] <= wdata_w;
    end
  end

  // Trim amount taken as a plain unsigned byte
  always_ff @(posedge clk) begin
    if (srst) bias_trim_amount_r <= BYTE_RST;
    else if (wr_trim_amt) bias_trim_amount_r <= wdata_w;
  end

  // Per-axis trim enables
  always_ff @(posedge clk) begin
    if (srst) begin
      trim_enable_x_r <= 1'b0;
      trim_enable_y_r <= 1'b0;
    end else if (wr_trim_en) begin
      trim_enable_x_r <= wdata_w[TRIMX_BIT];
      trim_enable_y_r <= wdata_w[TRIMY_BIT];
    end
  end

  // Threshold codes and detect enable; any code pair is accepted
  always_ff @(posedge clk) begin
    if (srst) field_cfg_r <= FIELD_CFG_RST;
    else if (wr_field_cfg) field_cfg_r <= wdata_w;
  end

  // Rotation direction select
  always_ff @(posedge clk) begin
    if (srst) dir_r <= 1'b0;
    else if (wr_dir) dir_r <= wdata_w[DIR_BIT];
  end

  // ****************************************
  // Angle output
  // ****************************************

  // Plain 16-bit arithmetic wraps modulo one turn by itself.
  // Reversal negates the raw angle before the offset is removed.
  assign angle_nxt = dir_r ? (ANGLE_W'(0) - raw_angle - zero_r)
                           : (raw_angle - zero_r);

  // Registered so the pin and the reply see one value per cycle
  always_ff @(posedge clk) begin
    if (srst) angle_r <= ANGLE_RST;
    else angle_r <= angle_nxt;
  end

  assign angle_out = angle_r;

  // ****************************************
  // Bias trim to the front end
  // ****************************************

  // Each axis sees the amount only when its own enable is set;
  // with both set the two axes shrink alike, which gives no
  // side-shaft correction
  always_ff @(posedge clk) begin
    if (srst) begin
      trim_x <= BYTE_RST;
      trim_y <= BYTE_RST;
    end else begin
      trim_x <= trim_enable_x_r ? bias_trim_amount_r : BYTE_RST;
      trim_y <= trim_enable_y_r ? bias_trim_amount_r : BYTE_RST;
    end
  end

  // ****************************************
  // Field alarms
  // ****************************************

  // Equal trim on both axes shrinks the measured signal, so a larger
  // amount needs a stronger field to reach the same level.
  // Full scale 256 stands in for 258 to keep this a shift.
  assign both_trim   = trim_enable_x_r && trim_enable_y_r;
  assign scaled_prod = 17'(field_mt) * 17'(TRIM_FULL - 9'(bias_trim_amount_r));
  assign field_eff   = both_trim ? scaled_prod[15:8]
                                 : field_mt;

  assign detect_en = field_cfg_r[DETECT_BIT];
  assign code_w[0] = field_cfg_r[LOWT_LSB +: CODE_W];
  assign code_w[1] = field_cfg_r[HIGHT_LSB +: CODE_W];

  // Index 0 is the low side, index 1 the high side
  generate
    for (genvar g = 0; g < 2; g++) begin : g_alarm
      asr_field_alarm #(
        .HIGH_SIDE (1'(g))
      ) u_alarm (
        .clk    (clk),
        .srst   (srst),
        .enable (detect_en),
        .code   (code_w[g]),
        .field  (field_eff),
        .flag   (flag_w[g])
      );
    end
  endgenerate

  // Flags go to their own pins as well as the status byte
  assign low_field_flag  = flag_w[0];
  assign high_field_flag = flag_w[1];

  // Status byte: lower six bits read as zero
  always_comb begin
    status_w = BYTE_RST;
    status_w[HIGHF_BIT] = flag_w[1];
    status_w[LOWF_BIT]  = flag_w[0];
  end

  // ****************************************
  // Register read mux
  // ****************************************

  // Unknown addresses read as zero
  always_comb begin
    rd_data = BYTE_RST;
    if (reply_addr_r == ADDR_ZERO_LO) begin
      rd_data = zero_r[DATA_W-1:0];
    end else if (reply_addr_r == ADDR_ZERO_HI) begin
      rd_data = zero_r[ANGLE_W-1:DATA_W];
    end else if (reply_addr_r == ADDR_TRIM_AMT) begin
      rd_data = bias_trim_amount_r;
    end else if (reply_addr_r == ADDR_TRIM_EN) begin
      rd_data[TRIMX_BIT] = trim_enable_x_r;
      rd_data[TRIMY_BIT] = trim_enable_y_r;
    end else if (reply_addr_r == ADDR_FIELD_CFG) begin
      rd_data = field_cfg_r;
    end else if (reply_addr_r == ADDR_DIR) begin
      rd_data[DIR_BIT] = dir_r;
    end else if (reply_addr_r == ADDR_FIELD_ST) begin
      rd_data = status_w;
    end
  end

  // ****************************************
  // Reply word for the next frame
  // ****************************************

  // A read or write frame arms a register reply; others the angle
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r       <= 1'b0;
      reply_addr_r <= ADDR_ZERO_LO;
    end else if (frame_evt) begin
      pend_r       <= rd_evt || wr_evt;
      reply_addr_r <= addr_w;
    end
  end

  // High angle byte plus register value, or the full angle
  assign reply_nxt = pend_r ? {angle_r[ANGLE_W-1:DATA_W], rd_data}
                            : angle_r;

  // Frozen while selected: the sclk side reads it without a
  // handshake, so it must not move during a frame. Limitation:
  // the host waits three clk periods after selecting.
  always_ff @(posedge clk) begin
    if (srst) reply_r <= ANGLE_RST;
    else if (cs_s2_r) reply_r <= reply_nxt;
  end

  assign lk.reply_word = reply_r;

endmodule

// ===== test/asr_angle_cfg_assertions.sv
// Port-level checks for the angle sensor register block.
// Assumes one core clock clk and synchronous active-high srst.
`timescale 1ns/1ps
module asr_angle_cfg_assertions (
  input wire logic                         clk,
  input wire logic                         srst,
  input wire logic                         cs_n,
  input wire logic                         miso_oe,
  input wire logic [asr_pkg::ANGLE_W-1:0]  raw_angle,
  input wire logic [asr_pkg::FIELD_W-1:0]  field_mt,
  input wire logic [asr_pkg::ANGLE_W-1:0]  angle_out,
  input wire logic [asr_pkg::DATA_W-1:0]   trim_x,
  input wire logic [asr_pkg::DATA_W-1:0]   trim_y,
  input wire logic                         low_field_flag,
  input wire logic                         high_field_flag
);
  import asr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Settings move only after a frame, so eight idle cycles mean settled
  a_angle_hold: assert property (
    cs_n [*8] ##0 $stable(raw_angle) |=> $stable(angle_out))
    else $error("angle moved with input and settings still");
  a_trim_hold: assert property (
    cs_n [*8] |=> $stable(trim_x) && $stable(trim_y))
    else $error("trim outputs moved without a frame");
  a_trim_equal: assert property (
    trim_x != 8'h00 && trim_y != 8'h00 |-> trim_x == trim_y)
    else $error("both axes trimmed by different amounts");
  // Lowest release level is 20 mT, highest low threshold 126 mT
  a_high_clear: assert property (
    field_mt < 8'h14 |=> !high_field_flag)
    else $error("high flag set below lowest release level");
  a_low_clear: assert property (
    field_mt >= 8'h7e ##1 trim_x == 8'h00 |-> !low_field_flag)
    else $error("low flag set above highest threshold");
  // A second look at a steady field must not flip a flag
  a_high_hold: assert property (
    cs_n [*8] ##0 $stable(field_mt) |=> $stable(high_field_flag))
    else $error("high flag moved with field steady");
  a_low_hold: assert property (
    cs_n [*8] ##0 $stable(field_mt) |=> $stable(low_field_flag))
    else $error("low flag moved with field steady");
  a_oe_select: assert property (
    $fell(cs_n) |-> miso_oe ##0 !cs_n)
    else $error("data out not driven while selected");
endmodule

bind asr_angle_cfg asr_angle_cfg_assertions chk_u (
  .clk(clk), .srst(srst), .cs_n(cs_n), .miso_oe(miso_oe),
  .raw_angle(raw_angle), .field_mt(field_mt), .angle_out(angle_out),
  .trim_x(trim_x), .trim_y(trim_y), .low_field_flag(low_field_flag),
  .high_field_flag(high_field_flag));

// ===== test/asr_spi_host_model.sv
// SPI host model: mode 0, MSB first, 16-bit frames.
// Assumes the device answers each frame in the one that follows.
`timescale 1ns/1ps
module asr_spi_host_model (
  output logic     sclk,
  output logic     cs_n,
  output logic     mosi,
  input wire logic miso
);
  // Link clock of 12 ns, still outside frames
  localparam time HALF = 6ns;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    // Deselect after time zero so the shifter's async clear sees an edge
    #1ns cs_n = 1'b1;
  end

  // One whole frame; setup and gap exceed the device minimums
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #100ns;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #HALF sclk = 1'b1;
      rx[i] = miso;
      #HALF sclk = 1'b0;
    end
    mosi = 1'b0; // Line driven low again after the last bit
    #HALF cs_n = 1'b1;
    #200ns;
  endtask
endmodule

// ===== test/asr_angle_cfg_bench.sv
// Self-checking bench for the angle sensor register block.
// Assumes the host model drives the SPI pins on its own clock.
`timescale 1ns/1ps
module asr_angle_cfg_bench;
  import asr_pkg::*;
  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] val;
  } asr_note_t;

  logic        clk = 1'b0, srst;
  logic [15:0] raw_angle = 16'h1234, ref_zero = 16'h0000, rx_word, v;
  logic [7:0]  field_mt = 8'h30, ref_trim = 8'h00, ref_st = 8'h00;
  logic [7:0]  ref_cfg = FIELD_CFG_RST, trim_x, trim_y;
  logic        sclk, cs_n, mosi, miso, miso_oe, ref_dir = 1'b0;
  logic        low_field_flag, high_field_flag, pend_ok = 1'b0;
  logic [15:0] angle_out;
  logic [1:0]  ref_en = 2'h0;
  logic [2:0]  pend_op;
  logic [4:0]  pend_addr;
  logic [31:0] lfsr_r = 32'h8175c0a1;
  logic [2:0]  ops [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  int          fails = 0, cmp_count = 0;
  asr_note_t   notes[$], mon_n;
  event        rx_ev;

  always #12.5 clk = ~clk;

  asr_angle_cfg dut_u (
    .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .raw_angle(raw_angle),
    .field_mt(field_mt), .angle_out(angle_out), .trim_x(trim_x),
    .trim_y(trim_y), .low_field_flag(low_field_flag),
    .high_field_flag(high_field_flag));
  asr_spi_host_model host_u (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ****************************************
  // Reference model and helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_angle();
    return ref_dir ? 16'h0000 - raw_angle - ref_zero : raw_angle - ref_zero;
  endfunction
  function automatic logic [7:0] reg_value(input logic [4:0] a);
    case (a)
      ADDR_ZERO_LO:   return ref_zero[7:0];
      ADDR_ZERO_HI:   return ref_zero[15:8];
      ADDR_TRIM_AMT:  return ref_trim;
      ADDR_TRIM_EN:   return {6'h00, ref_en};
      ADDR_FIELD_CFG: return ref_cfg;
      ADDR_DIR:       return {ref_dir, 7'h00};
      ADDR_FIELD_ST:  return ref_st;
      default:        return 8'h00;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Notes the reply owed by the last frame, then runs one frame
  task automatic spi(input logic [2:0] op, input logic [4:0] a,
                     input logic [7:0] d);
    logic        rw;
    logic [15:0] ang;
    ang = exp_angle();
    rw = pend_op == OP_READ || pend_op == OP_WRITE;
    notes.push_back(asr_note_t'{!pend_ok ? 16'h0000 :
      (rw && pend_addr == ADDR_FIELD_ST) ? 16'hffc0 : 16'hffff,
      rw ? {ang[15:8], reg_value(pend_addr)} : ang});
    host_u.xfer({op, a, d}, rx_word);
    -> rx_ev;
    if (op == OP_WRITE) begin
      case (a)
        ADDR_ZERO_LO:   ref_zero[7:0] = d;
        ADDR_ZERO_HI:   ref_zero[15:8] = d;
        ADDR_TRIM_AMT:  ref_trim = d;
        ADDR_TRIM_EN:   ref_en = d[1:0];
        ADDR_FIELD_CFG: ref_cfg = d;
        ADDR_DIR:       ref_dir = d[7];
        default:        ;
      endcase
    end
    pend_ok = 1'b1;
    pend_op = op;
    pend_addr = a;
    @(negedge clk);
  endtask

  // Flags settle one cycle after the field; three leave margin
  task automatic fld(input logic [7:0] f, input logic [1:0] e);
    @(posedge clk) field_mt <= f;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("flags", 16'({high_field_flag, low_field_flag}), 16'(e));
  endtask

  // Compares each reply but the first against the oldest note
  always @(rx_ev) begin
    mon_n = notes.pop_front();
    if (mon_n.mask !== 16'h0000)
      check("spi reply", rx_word & mon_n.mask, mon_n.val & mon_n.mask);
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    // A real edge on reset, so the link side clears its toggle too
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset values, unmapped places and a refused status write
    for (int a = 0; a < 32; a += 3)
      spi(OP_READ, 5'(a), 8'h00);
    spi(OP_WRITE, ADDR_FIELD_ST, 8'hff);
    $display("test reset values done");
    // First offset sits one above the angle to force the wrap
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      v = lfsr_r[15:0];
      @(posedge clk) raw_angle <= v;
      repeat (4) @(posedge clk);
      lfsr_r = lfsr_next(lfsr_r);
      v = (i == 0) ? v + 16'h0001 : lfsr_r[31:16];
      spi(OP_WRITE, ADDR_ZERO_LO, v[7:0]);
      spi(OP_WRITE, ADDR_ZERO_HI, v[15:8]);
      check("angle_out", angle_out, exp_angle());
    end
    spi(OP_WRITE, ADDR_DIR, 8'h80);
    check("angle_out", angle_out, exp_angle());
    spi(OP_WRITE, ADDR_DIR, 8'h00);
    $display("test zero and direction done");
    spi(OP_WRITE, ADDR_TRIM_AMT, 8'h81); // Ratio of two gives 129
    for (int e = 0; e < 4; e++) begin
      spi(OP_WRITE, ADDR_TRIM_EN, 8'(e));
      check("trim_x", 16'(trim_x), e[0] ? 16'h0081 : 16'h0000);
      check("trim_y", 16'(trim_y), e[1] ? 16'h0081 : 16'h0000);
    end
    spi(OP_WRITE, ADDR_TRIM_EN, 8'h00);
    $display("test trim done");
    // Both edges of every threshold code, with hysteresis
    for (int c = 0; c < 8; c++) begin
      spi(OP_WRITE, ADDR_FIELD_CFG, {1'b0, 3'(c), 3'(c), 1'b1});
      fld(RISE_MT[c], 2'b10);
      fld(RISE_MT[c] - HYST_MT, 2'b10);
      fld(RISE_MT[c] - HYST_MT - 8'h01, 2'b01);
      fld(RISE_MT[c] - 8'h01, 2'b01);
    end
    spi(OP_WRITE, ADDR_FIELD_CFG, 8'h71);
    fld(8'h7d, 2'b11);
    ref_st = 8'hc0;
    spi(OP_READ, ADDR_FIELD_ST, 8'h00);
    spi(OP_WRITE, ADDR_FIELD_CFG, 8'h70);
    ref_st = 8'h00;
    fld(8'h7d, 2'b00);
    // Equal trim on both axes shrinks the field seen
    spi(OP_WRITE, ADDR_FIELD_CFG, 8'h01);
    spi(OP_WRITE, ADDR_TRIM_EN, 8'h03);
    fld(8'h0a, 2'b01);
    fld(8'h28, 2'b01);
    spi(OP_WRITE, ADDR_TRIM_EN, 8'h00);
    fld(8'h28, 2'b10);
    foreach (ops[j])
      spi(ops[j], ADDR_FIELD_CFG, 8'hff);
    spi(OP_READ, ADDR_FIELD_CFG, 8'h00);
    spi(OP_READ, ADDR_ZERO_LO, 8'h00);
    $display("test field alarms and opcodes done");
    stop_test();
  end

  // Watchdog: the run needs under 100 us, so 300 us means a hang
  initial begin
    #300000;
    fails++;
    stop_test();
  end
endmodule
